// ---- rtl/nand_host_cfg.svh ----
// Constants for the serial NAND host controller
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH
// ----------------------------------------------------------------------------
// Instruction opcodes
// ----------------------------------------------------------------------------
`define NH_OPC_WREN    8'h06
`define NH_OPC_LOAD    8'h02
`define NH_OPC_RLOAD   8'h84
`define NH_OPC_QLOAD   8'h32
`define NH_OPC_QRLOAD  8'h34
`define NH_OPC_EXEC    8'h10
`define NH_OPC_PREAD   8'h13
`define NH_OPC_READ    8'h03
`define NH_OPC_FREAD   8'h0b
`define NH_OPC_RDSR    8'h0f
`define NH_OPC_NONE    8'h00
// ----------------------------------------------------------------------------
// Status register 3 and its flags
// ----------------------------------------------------------------------------
`define NH_SR3_ADDR    8'hc0
`define NH_BUSY_BIT    0
// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define NH_PAGE_BYTES  17'h00880
`define NH_COL_W       12
`define NH_PG_IN_BLK_W 6
`define NH_PLANE_BIT   6
// ----------------------------------------------------------------------------
// Frame layout: header length in bytes, dummy byte counts
// ----------------------------------------------------------------------------
`define NH_HDR_CMD     3'h1
`define NH_HDR_REG     3'h2
`define NH_HDR_COL     3'h3
`define NH_HDR_PAGE    3'h4
`define NH_DUM_BUF     3'h1
`define NH_DUM_RD_SEQ  3'h3
`define NH_DUM_FR_SEQ  3'h4
`define NH_HDR_W       56
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define NH_CS_HIGH_NS  100
`define NH_CLK_NS      10
`define NH_GAP_CYC     ((`NH_CS_HIGH_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_HALF_DEF    4
`endif

// ---- rtl/nand_host_pkg.sv ----
// Types shared by the serial NAND host controller
package nand_host_pkg;
   typedef enum logic [3:0] {
      OP_LOAD   = 4'h0,
      OP_RLOAD  = 4'h1,
      OP_QLOAD  = 4'h2,
      OP_QRLOAD = 4'h3,
      OP_EXEC   = 4'h4,
      OP_PREAD  = 4'h5,
      OP_READ   = 4'h6,
      OP_FREAD  = 4'h7,
      OP_STATUS = 4'h8
   } op_type;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_HDR  = 5'b00010,
      ST_TX   = 5'b00100,
      ST_RX   = 5'b01000,
      ST_GAP  = 5'b10000
   } state_type;

   typedef enum logic [1:0] {
      FR_WREN = 2'h0,
      FR_MAIN = 2'h1,
      FR_POLL = 2'h2
   } frame_type;
endpackage : nand_host_pkg

// ---- rtl/spi_byte_if.sv ----
// Byte handshake between the sequencer and the SPI shift engine
`timescale 1ns/10ps
interface spi_byte_if;
   logic       start;
   logic [7:0] tx_byte;
   logic       quad;
   logic       ready;
   logic       done;
   logic [7:0] rx_byte;

   modport ctrl   (output start, output tx_byte, output quad,
                   input ready, input done, input rx_byte);
   modport engine (input start, input tx_byte, input quad,
                   output ready, output done, output rx_byte);
endinterface : spi_byte_if

// ---- rtl/spi_shift_engine.sv ----
// SPI mode 0 byte shifter with divided serial clock
`timescale 1ns/10ps
`include "nand_host_cfg.svh"
module spi_shift_engine #(
   parameter int HALF = `NH_HALF_DEF
) (
   input  wire logic  core_clk_in,
   input  wire logic  srst_in,
   spi_byte_if.engine bif,
   output logic       sclk_out,
   input  wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_out
);
   // Two sync stages plus output delay must fit in the low half
   initial begin
      if (HALF < 4 || HALF > 256) $error("HALF must be 4 to 256");
   end

   logic [7:0] shreg_ff;
   logic [7:0] rxsh_ff;
   logic [3:0] bits_ff;
   logic [7:0] div_ff;
   logic       busy_ff;
   logic       quad_ff;
   logic       sclk_ff;
   logic       done_ff;
   logic [3:0] io_meta_ff;
   logic [3:0] io_sync_ff;
   logic       tick;

   assign tick = (div_ff == 8'(HALF - 1));

   // ---------------------------------------------------------------------------
   // Pin input synchroniser
   // ---------------------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      io_meta_ff <= io_in;
      io_sync_ff <= io_meta_ff;
   end

   // ---------------------------------------------------------------------------
   // Divider and bit sequencing
   // ---------------------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         busy_ff <= 1'b0;
         sclk_ff <= 1'b0;
         done_ff <= 1'b0;
         div_ff  <= 8'h00;
         bits_ff <= 4'h0;
         quad_ff <= 1'b0;
         shreg_ff <= 8'h00;
         rxsh_ff <= 8'h00;
      end else begin
         done_ff <= 1'b0;
         if (!busy_ff) begin
            if (bif.start) begin
               busy_ff  <= 1'b1;
               shreg_ff <= bif.tx_byte;
               quad_ff  <= bif.quad;
               bits_ff  <= bif.quad ? 4'h2 : 4'h8;
               div_ff   <= 8'h00;
            end
         end else if (!tick) begin
            div_ff <= div_ff + 8'h01;
         end else begin
            div_ff <= 8'h00;
            if (!sclk_ff) begin
               // Device drives on falling edges; sample at our rising edge
               sclk_ff <= 1'b1;
               rxsh_ff <= quad_ff ? {rxsh_ff[3:0], io_sync_ff} : {rxsh_ff[6:0], io_sync_ff[1]};
            end else begin
               sclk_ff  <= 1'b0;
               shreg_ff <= quad_ff ? {shreg_ff[3:0], 4'h0} : {shreg_ff[6:0], 1'b0};
               bits_ff  <= bits_ff - 4'h1;
               if (bits_ff == 4'h1) begin
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
               end
            end
         end
      end
   end

   assign bif.ready   = !busy_ff;
   assign bif.done    = done_ff;
   assign bif.rx_byte = rxsh_ff;
   assign sclk_out    = sclk_ff;
   // Single mode keeps write-protect and hold lines high
   assign io_out      = (busy_ff && quad_ff) ? shreg_ff[7:4] : {2'b11, 1'b0, shreg_ff[7]};
   assign io_oe_out   = (busy_ff && quad_ff) ? 4'b1111 : 4'b1101;
endmodule : spi_shift_engine

// ---- rtl/nand_host_ctrl.sv ----
// Host sequencer driving a serial NAND program and read path
`timescale 1ns/10ps
`include "nand_host_cfg.svh"
module nand_host_ctrl #(
   parameter int HALF = `NH_HALF_DEF
) (
   input  wire logic                 core_clk_in,
   input  wire logic                 srst_in,
   input  wire logic                 cmd_valid_in,
   output logic                      cmd_ready_out,
   input  wire nand_host_pkg::op_type cmd_op_in,
   input  wire logic [23:0]          addr_in,
   input  wire logic [15:0]          len_in,
   input  wire logic                 buf_mode_in,
   input  wire logic                 quad_disable_in,
   input  wire logic [7:0]           wr_data_in,
   input  wire logic                 wr_valid_in,
   output logic                      wr_ready_out,
   output logic [7:0]                rd_data_out,
   output logic                      rd_valid_out,
   output logic                      done_out,
   output logic                      err_out,
   output logic [7:0]                status_out,
   output logic                      cs_n_out,
   output logic                      sclk_out,
   input  wire logic [3:0]           io_in,
   output logic [3:0]                io_out,
   output logic [3:0]                io_oe_out
);
   import nand_host_pkg::*;

   spi_byte_if bif ();

   state_type  state_ff;
   state_type  nxt_state;
   frame_type  frame_ff;
   op_type     op_ff;
   logic [23:0] addr_ff;
   logic        buf_ff;
   logic [15:0] cnt_ff;
   logic [2:0]  idx_ff;
   logic [3:0]  gap_ff;
   logic [7:0]  rd_data_ff;
   logic        rd_valid_ff;
   logic        done_ff;
   logic        err_ff;
   logic [7:0]  status_ff;
   logic        cs_n_ff;
   logic [23:0] last_page_ff;
   logic        last_ok_ff;
   logic        plane_ff;
   logic        plane_ok_ff;
   logic        accept;
   logic        bad_cmd;
   logic        go;
   logic        hdr_last;
   logic        gap_end;

   // ---------------------------------------------------------------------------
   // Frame decoding
   // ---------------------------------------------------------------------------
   function automatic logic is_load(input op_type op);
      return op inside {OP_LOAD, OP_RLOAD, OP_QLOAD, OP_QRLOAD};
   endfunction : is_load

   function automatic logic is_quad(input op_type op);
      return op inside {OP_QLOAD, OP_QRLOAD};
   endfunction : is_quad

   function automatic logic [7:0] opcode(input frame_type fr, input op_type op);
      logic [7:0] r;
      r = `NH_OPC_NONE;
      if (fr == FR_WREN) r = `NH_OPC_WREN;
      else if (fr == FR_POLL) r = `NH_OPC_RDSR;
      else begin
         unique case (op)
            OP_LOAD:   r = `NH_OPC_LOAD;
            OP_RLOAD:  r = `NH_OPC_RLOAD;
            OP_QLOAD:  r = `NH_OPC_QLOAD;
            OP_QRLOAD: r = `NH_OPC_QRLOAD;
            OP_EXEC:   r = `NH_OPC_EXEC;
            OP_PREAD:  r = `NH_OPC_PREAD;
            OP_READ:   r = `NH_OPC_READ;
            OP_FREAD:  r = `NH_OPC_FREAD;
            OP_STATUS: r = `NH_OPC_RDSR;
            default:   r = `NH_OPC_NONE;
         endcase
      end
      return r;
   endfunction : opcode

   function automatic logic [2:0] hdr_len(input frame_type fr, input op_type op,
                                          input logic bufm);
      logic [2:0] r;
      r = `NH_HDR_CMD;
      if (fr == FR_POLL || (fr == FR_MAIN && op == OP_STATUS)) r = `NH_HDR_REG;
      else if (fr == FR_MAIN) begin
         if (op inside {OP_EXEC, OP_PREAD}) r = `NH_HDR_PAGE;
         else if (op == OP_READ)
            r = `NH_HDR_COL + (bufm ? `NH_DUM_BUF : `NH_DUM_RD_SEQ);
         else if (op == OP_FREAD)
            r = `NH_HDR_COL + (bufm ? `NH_DUM_BUF : `NH_DUM_FR_SEQ);
         else r = `NH_HDR_COL;
      end
      return r;
   endfunction : hdr_len

   logic [`NH_HDR_W-1:0] hdr_vec;
   logic [7:0]           hdr_byte;

   always_comb begin
      hdr_vec = '0;
      if (frame_ff == FR_POLL)
         hdr_vec = {opcode(frame_ff, op_ff), `NH_SR3_ADDR, 40'h0};
      else if (frame_ff == FR_MAIN && op_ff == OP_STATUS)
         hdr_vec = {opcode(frame_ff, op_ff), addr_ff[7:0], 40'h0};
      else if (frame_ff == FR_MAIN && op_ff inside {OP_EXEC, OP_PREAD})
         hdr_vec = {opcode(frame_ff, op_ff), addr_ff, 24'h0};
      else if (frame_ff == FR_MAIN)
         hdr_vec = {opcode(frame_ff, op_ff), 4'h0, addr_ff[`NH_COL_W-1:0], 32'h0};
      else
         hdr_vec = {opcode(frame_ff, op_ff), 48'h0};
      hdr_byte = hdr_vec[(`NH_HDR_W - 1) - 8 * int'(idx_ff) -: 8];
   end

   // ---------------------------------------------------------------------------
   // Command checks
   // ---------------------------------------------------------------------------
   logic [16:0] load_end;
   assign load_end = {5'h00, addr_in[`NH_COL_W-1:0]} + {1'b0, len_in};

   always_comb begin
      bad_cmd = 1'b0;
      if (is_load(cmd_op_in) && (len_in == 16'h0000 || load_end > `NH_PAGE_BYTES))
         bad_cmd = 1'b1;
      if (is_quad(cmd_op_in) && quad_disable_in) bad_cmd = 1'b1;
      if (cmd_op_in inside {OP_READ, OP_FREAD} && len_in == 16'h0000) bad_cmd = 1'b1;
      if (cmd_op_in == OP_EXEC && last_ok_ff
          && addr_in[23:`NH_PG_IN_BLK_W] == last_page_ff[23:`NH_PG_IN_BLK_W]
          && addr_in[`NH_PG_IN_BLK_W-1:0] <= last_page_ff[`NH_PG_IN_BLK_W-1:0])
         bad_cmd = 1'b1;
      if (cmd_op_in == OP_EXEC && plane_ok_ff && addr_in[`NH_PLANE_BIT] != plane_ff)
         bad_cmd = 1'b1;
   end

   assign cmd_ready_out = (state_ff == ST_IDLE);
   assign accept        = cmd_valid_in && cmd_ready_out && !bad_cmd;

   // ---------------------------------------------------------------------------
   // Byte issue to the shift engine
   // ---------------------------------------------------------------------------
   assign go           = bif.ready && !bif.done;
   assign wr_ready_out = (state_ff == ST_TX) && go;
   assign bif.start    = ((state_ff == ST_HDR || state_ff == ST_RX) && go)
                         || (wr_ready_out && wr_valid_in);
   assign bif.tx_byte  = (state_ff == ST_TX) ? wr_data_in : hdr_byte;
   assign bif.quad     = (state_ff == ST_TX) && is_quad(op_ff);
   assign hdr_last     = (idx_ff == hdr_len(frame_ff, op_ff, buf_ff) - 3'h1);
   assign gap_end      = (gap_ff == 4'h0);

   // ---------------------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: if (accept) nxt_state = ST_HDR;
         ST_HDR: if (bif.done && hdr_last) begin
            if (frame_ff == FR_POLL || (frame_ff == FR_MAIN
                && op_ff inside {OP_READ, OP_FREAD, OP_STATUS}))
               nxt_state = ST_RX;
            else if (frame_ff == FR_MAIN && is_load(op_ff)) nxt_state = ST_TX;
            else nxt_state = ST_GAP;
         end
         ST_TX: if (bif.done && cnt_ff == 16'h0001) nxt_state = ST_GAP;
         ST_RX: if (bif.done && (frame_ff == FR_POLL || op_ff == OP_STATUS
                                 || cnt_ff == 16'h0001))
            nxt_state = ST_GAP;
         ST_GAP: if (gap_end) begin
            if (frame_ff == FR_WREN) nxt_state = ST_HDR;
            else if (frame_ff == FR_MAIN && op_ff inside {OP_EXEC, OP_PREAD})
               nxt_state = ST_HDR;
            else if (frame_ff == FR_POLL && status_ff[`NH_BUSY_BIT])
               nxt_state = ST_HDR;
            else nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) state_ff <= ST_IDLE;
      else state_ff <= nxt_state;
   end

   // Chip select stays low across stalls of the write stream
   always_ff @(posedge core_clk_in) begin
      if (srst_in) cs_n_ff <= 1'b1;
      else cs_n_ff <= !(nxt_state inside {ST_HDR, ST_TX, ST_RX});
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         frame_ff <= FR_WREN;
         op_ff    <= OP_STATUS;
         addr_ff  <= 24'h0;
         buf_ff   <= 1'b0;
      end else if (accept) begin
         // Loads are always preceded by write enable
         frame_ff <= is_load(cmd_op_in) ? FR_WREN : FR_MAIN;
         op_ff    <= cmd_op_in;
         addr_ff  <= addr_in;
         buf_ff   <= buf_mode_in;
      end else if (state_ff == ST_GAP && gap_end) begin
         // Busy device would ignore anything but status polls
         if (frame_ff == FR_WREN) frame_ff <= FR_MAIN;
         else frame_ff <= FR_POLL;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) idx_ff <= 3'h0;
      else if (state_ff != ST_HDR) idx_ff <= 3'h0;
      else if (bif.done) idx_ff <= idx_ff + 3'h1;
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) cnt_ff <= 16'h0000;
      else if (accept) cnt_ff <= len_in;
      else if ((state_ff == ST_TX || (state_ff == ST_RX && frame_ff == FR_MAIN))
               && bif.done)
         cnt_ff <= cnt_ff - 16'h0001;
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) gap_ff <= 4'h0;
      else if (state_ff != ST_GAP) gap_ff <= 4'(`NH_GAP_CYC - 1);
      else if (!gap_end) gap_ff <= gap_ff - 4'h1;
   end

   // ---------------------------------------------------------------------------
   // Results
   // ---------------------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         rd_data_ff  <= 8'h00;
         rd_valid_ff <= 1'b0;
         status_ff   <= 8'h00;
      end else begin
         rd_valid_ff <= 1'b0;
         if (state_ff == ST_RX && bif.done) begin
            if (frame_ff == FR_POLL) status_ff <= bif.rx_byte;
            else begin
               rd_data_ff  <= bif.rx_byte;
               rd_valid_ff <= 1'b1;
               if (op_ff == OP_STATUS) status_ff <= bif.rx_byte;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         done_ff <= 1'b0;
         err_ff  <= 1'b0;
      end else begin
         err_ff  <= cmd_valid_in && cmd_ready_out && bad_cmd;
         done_ff <= (state_ff == ST_GAP) && (nxt_state == ST_IDLE);
      end
   end

   // Page order and plane tracking
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         last_page_ff <= 24'h0;
         last_ok_ff   <= 1'b0;
         plane_ff     <= 1'b0;
         plane_ok_ff  <= 1'b0;
      end else if (accept) begin
         if (cmd_op_in == OP_EXEC) begin
            last_page_ff <= addr_in;
            last_ok_ff   <= 1'b1;
         end
         if (cmd_op_in == OP_PREAD) begin
            plane_ff    <= addr_in[`NH_PLANE_BIT];
            plane_ok_ff <= 1'b1;
         end
         if (cmd_op_in inside {OP_LOAD, OP_QLOAD}) plane_ok_ff <= 1'b0;
      end
   end

   assign rd_data_out  = rd_data_ff;
   assign rd_valid_out = rd_valid_ff;
   assign done_out     = done_ff;
   assign err_out      = err_ff;
   assign status_out   = status_ff;
   assign cs_n_out     = cs_n_ff;

   spi_shift_engine #(.HALF(HALF)) u_engine (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .bif         (bif.engine),
      .sclk_out    (sclk_out),
      .io_in       (io_in),
      .io_out      (io_out),
      .io_oe_out   (io_oe_out)
   );
endmodule : nand_host_ctrl

// ---- bench/nand_host_sva.sv ----
// Assertions on the serial NAND host controller ports
`timescale 1ns/10ps
module nand_host_sva #(
   parameter int HALF = 4
) (
   input wire logic                  core_clk_in,
   input wire logic                  srst_in,
   input wire logic                  cmd_valid_in,
   input wire logic                  cmd_ready_out,
   input wire nand_host_pkg::op_type cmd_op_in,
   input wire logic [15:0]           len_in,
   input wire logic                  quad_disable_in,
   input wire logic                  done_out,
   input wire logic                  err_out,
   input wire logic [7:0]            status_out,
   input wire logic                  cs_n_out,
   input wire logic                  sclk_out,
   input wire logic [3:0]            io_oe_out
);
   import nand_host_pkg::*;
   logic busy_op_ff;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   sequence take_s;
      cmd_valid_in && cmd_ready_out;
   endsequence
   sequence rd_s;
      take_s ##0 (cmd_op_in inside {OP_READ, OP_FREAD} && len_in != 16'h0);
   endsequence
   // Remembers whether the running command waits on the busy flag
   always_ff @(posedge core_clk_in) begin
      if (srst_in) busy_op_ff <= 1'b0;
      else if (cmd_valid_in && cmd_ready_out) busy_op_ff <= cmd_op_in inside {OP_EXEC, OP_PREAD};
   end
   quad_refuse_a: assert property (take_s ##0 (cmd_op_in inside {OP_QLOAD, OP_QRLOAD})
      ##0 quad_disable_in |=> err_out) else $error("quad load not refused");
   zero_len_a: assert property (take_s ##0 (cmd_op_in == OP_LOAD && len_in == 16'h0)
      |=> err_out) else $error("empty load not refused");
   read_frame_a: assert property (rd_s |-> ##[1:20] !cs_n_out)
      else $error("read frame did not start");
   err_idle_a: assert property (err_out |-> !$past(cs_n_out, 1) == 1'b0 ##1 !err_out)
      else $error("refusal not a single pulse");
   cs_idle_a: assert property (cmd_ready_out |-> cs_n_out && !sclk_out)
      else $error("idle bus not quiet");
   single_lane_a: assert property (quad_disable_in |-> io_oe_out == 4'hd)
      else $error("quad lanes driven while disabled");
   busy_done_a: assert property (done_out && busy_op_ff |-> status_out[0] == 1'b0)
      else $error("done before busy cleared");
   cs_gap_a: assert property ($rose(cs_n_out) |-> cs_n_out [*8])
      else $error("chip select gap too short");
endmodule : nand_host_sva

// ---- bench/nand_dev_model.sv ----
// Behavioural serial NAND device at the far end of the link
`timescale 1ns/10ps
module nand_dev_model #(
   parameter int PP_NS = 3000,
   parameter int RD_NS = 1500
) (
   input  wire logic       cs_n_in,
   input  wire logic       sclk_in,
   input  wire logic [3:0] io_in,
   input  wire logic       buf_mode_in,
   output logic            do_out
);
   logic [7:0] mem [0:2175];
   logic [7:0] sh, op, ob;
   logic [23:0] hdr;
   logic write_enable_latch = 0, busy = 0, oen = 0, stat = 0;
   int nbit, nbyte, col, ocol, obit;
   initial do_out = 1'b0;
   task automatic take(input logic [7:0] b);
      if (nbyte == 0) op = (busy && b != 8'h0f) ? 8'h00 : b;
      hdr = {hdr[15:0], b};
      if (nbyte == 2) col = int'(hdr[11:0]);
      if (op inside {8'h02, 8'h84, 8'h32, 8'h34} && !write_enable_latch) op = 8'h00;
      if (op inside {8'h02, 8'h32} && nbyte == 2) foreach (mem[i]) mem[i] = 8'hff;
      if (op inside {8'h02, 8'h84, 8'h32, 8'h34} && nbyte > 2) begin
         // ECC off: spare bytes kept as loaded
         if (col < 2176) mem[col] = b;
         col++;
      end
      if ((op == 8'h03 && nbyte == (buf_mode_in ? 3 : 5)) ||
          (op == 8'h0b && nbyte == (buf_mode_in ? 3 : 6)) || (op == 8'h0f && nbyte == 1)) begin
         oen = 1;
         stat = (op == 8'h0f);
         obit = 0;
         ocol = buf_mode_in ? col : 0;
      end
   endtask : take
   always @(negedge cs_n_in) begin
      nbit = 0;
      nbyte = 0;
   end
   always @(posedge sclk_in) if (!cs_n_in) begin
      if (nbyte > 2 && op inside {8'h32, 8'h34}) begin
         sh = {sh[3:0], io_in};
         nbit += 4;
      end else begin
         sh = {sh[6:0], io_in[0]};
         nbit++;
      end
      if (nbit == 8) begin
         nbit = 0;
         take(sh);
         nbyte++;
      end
   end
   always @(negedge sclk_in) if (!cs_n_in && oen) begin
      if (obit == 0) ob = stat ? {6'h0, write_enable_latch, busy} : mem[ocol % 2176];
      // Past the buffer end the pin floats; show a changing level
      if (!stat && buf_mode_in && ocol >= 2176) do_out = ~do_out;
      else do_out = ob[7 - obit];
      obit = (obit + 1) % 8;
      if (obit == 0) ocol++;
   end
   always @(posedge cs_n_in) begin
      oen = 0;
      do_out = ~do_out;
      if (op == 8'h06 && nbyte == 1) write_enable_latch = 1;
      // No array or protection modelled: execute only times busy
      if (op inside {8'h10, 8'h13} && nbyte == 4) begin
         busy = 1;
         if (op == 8'h13) foreach (mem[i]) mem[i] = hdr[7:0] ^ 8'(i);
         // Opcode decided now: later polls overwrite op
         if (op == 8'h10) fork
            begin
               #PP_NS;
               busy = 0;
               write_enable_latch = 0;
            end
         join_none
         else fork
            begin
               #RD_NS;
               busy = 0;
            end
         join_none
      end
   end
endmodule : nand_dev_model

// ---- bench/testbench.sv ----
// Self-checking bench for the serial NAND host controller
`timescale 1ns/10ps
module testbench;
   import nand_host_pkg::*;
   logic core_clk_in = 0, srst_in = 1, cmd_valid_in = 0, buf_mode_in = 0, quad_disable_in = 0;
   logic wr_valid_in = 0, got_err, dev_do, hung = 0;
   op_type cmd_op_in = OP_LOAD;
   logic [23:0] addr_in = '0;
   logic [15:0] len_in = '0;
   logic [7:0] wr_data_in = '0, rd_data_out, status_out;
   logic cmd_ready_out, wr_ready_out, rd_valid_out, done_out, err_out, cs_n_out, sclk_out;
   logic [3:0] io_out, io_oe_out, io_in;
   logic [7:0] wq[$], rq[$];
   int mismatches = 0, num_checks = 0;
   always #5 core_clk_in = ~core_clk_in;
   assign io_in = {io_out[3:2], io_oe_out[1] ? io_out[1] : dev_do, io_out[0]};
   nand_host_ctrl nand_host_ctrl_inst (.core_clk_in(core_clk_in), .srst_in(srst_in),
      .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
      .addr_in(addr_in), .len_in(len_in), .buf_mode_in(buf_mode_in),
      .quad_disable_in(quad_disable_in), .wr_data_in(wr_data_in), .wr_valid_in(wr_valid_in),
      .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .done_out(done_out), .err_out(err_out), .status_out(status_out), .cs_n_out(cs_n_out),
      .sclk_out(sclk_out), .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe_out));
   nand_dev_model nand_dev_model_inst (.cs_n_in(cs_n_out), .sclk_in(sclk_out), .io_in(io_out),
      .buf_mode_in(buf_mode_in), .do_out(dev_do));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic run(input op_type op, input logic [23:0] a, input logic [15:0] n,
                      input logic b, input logic exp_err);
      logic hs, fin;
      if (hung) return;
      got_err = 0;
      fin = 0;
      rq = {};
      @(posedge core_clk_in);
      cmd_valid_in <= 1;
      cmd_op_in <= op;
      addr_in <= a;
      len_in <= n;
      buf_mode_in <= b;
      wr_valid_in <= wq.size() > 0;
      if (wq.size() > 0) wr_data_in <= wq[0];
      @(posedge core_clk_in);
      cmd_valid_in <= 0;
      for (int k = 0; k < 50000 && !fin; k++) begin
         @(negedge core_clk_in);
         hs = wr_ready_out & wr_valid_in;
         if (rd_valid_out === 1'b1) rq.push_back(rd_data_out);
         if (err_out === 1'b1) got_err = 1;
         fin = (done_out === 1'b1) || got_err;
         @(posedge core_clk_in);
         if (hs) begin
            void'(wq.pop_front());
            wr_valid_in <= wq.size() > 0;
            if (wq.size() > 0) wr_data_in <= wq[0];
         end
      end
      // A hang is reported once; later commands are skipped
      if (!fin) begin
         check("completion", 16'h0, 16'h1);
         hung = 1;
      end
      check("refusal", {15'h0, got_err}, {15'h0, exp_err});
   endtask : run
   task automatic check_q(input logic [7:0] e[$]);
      check("read count", 16'(rq.size()), 16'(e.size()));
      foreach (e[i]) check("read byte", {8'h0, rq[i]}, {8'h0, e[i]});
   endtask : check_q
   initial begin
      repeat (8) @(posedge core_clk_in);
      srst_in <= 0;
      @(negedge core_clk_in);
      check("idle ready", {15'h0, cmd_ready_out}, 16'h1);
      check("idle select", {15'h0, cs_n_out}, 16'h1);
      wq = '{8'ha5, 8'h3c};
      run(OP_LOAD, 24'h5, 16'h2, 1'b1, 1'b0);
      run(OP_READ, 24'h4, 16'h3, 1'b1, 1'b0);
      check_q('{8'hff, 8'ha5, 8'h3c});
      $display("test load and buffer read done");
      wq = '{8'h11};
      run(OP_RLOAD, 24'h4, 16'h1, 1'b1, 1'b0);
      run(OP_FREAD, 24'h4, 16'h3, 1'b1, 1'b0);
      check_q('{8'h11, 8'ha5, 8'h3c});
      wq = '{8'hc3};
      run(OP_QLOAD, 24'h0, 16'h1, 1'b1, 1'b0);
      run(OP_READ, 24'h0, 16'h2, 1'b1, 1'b0);
      check_q('{8'hc3, 8'hff});
      run(OP_STATUS, 24'hc0, 16'h0, 1'b1, 1'b0);
      check("status latch", {8'h0, status_out}, 16'h2);
      $display("test random and quad load done");
      @(posedge core_clk_in);
      quad_disable_in <= 1;
      run(OP_QRLOAD, 24'h0, 16'h1, 1'b1, 1'b1);
      run(OP_LOAD, 24'h0, 16'h0, 1'b1, 1'b1);
      run(OP_LOAD, 24'h87f, 16'h2, 1'b1, 1'b1);
      $display("test refusals done");
      run(OP_EXEC, 24'h1, 16'h0, 1'b1, 1'b0);
      check("busy after program", {15'h0, status_out[0]}, 16'h0);
      run(OP_STATUS, 24'hc0, 16'h0, 1'b1, 1'b0);
      check("latch cleared", {8'h0, status_out}, 16'h0);
      run(OP_EXEC, 24'h1, 16'h0, 1'b1, 1'b1);
      $display("test program execute done");
      run(OP_PREAD, 24'h2, 16'h0, 1'b0, 1'b0);
      check("busy after page read", {15'h0, status_out[0]}, 16'h0);
      run(OP_READ, 24'h7, 16'h2, 1'b0, 1'b0);
      check_q('{8'h02, 8'h03});
      run(OP_FREAD, 24'h9, 16'h1, 1'b0, 1'b0);
      check_q('{8'h02});
      run(OP_EXEC, 24'h40, 16'h0, 1'b0, 1'b1);
      $display("test page read and sequential read done");
      conclude();
   end
endmodule : testbench
bind nand_host_ctrl nand_host_sva #(.HALF(HALF)) nand_host_sva_inst (
   .core_clk_in(core_clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
   .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in), .len_in(len_in),
   .quad_disable_in(quad_disable_in), .done_out(done_out), .err_out(err_out),
   .status_out(status_out), .cs_n_out(cs_n_out), .sclk_out(sclk_out), .io_oe_out(io_oe_out));
